//--- verilog/charger_regs_params.svh
// named offsets, bit positions, reset values and counts for the charger
// event mask and identification register block.
// assumes inclusion by the package and every design file that needs them.
//
// Functional notes
// - unused top id/mask bits read zero
// - id bits 5:3 hold read-only revision
// - id bits 2:0 hold read-only part code
// - mask1 bit7 masks input over-voltage event
// - mask1 bit6 masks input current regulation
// - mask1 bit5 masks battery voltage regulation
// - mask1 bit4 masks battery current regulation
// - mask1 bit3 masks output voltage regulation
// - mask1 bit2 masks input thermistor hot
// - mask1 bit1 masks battery thermistor hot
// - mask1 bit0 masks input reverse current
// - mask2 bit6 masks conversion complete event
// - mask2 bit5 masks switch drop alarm
// - mask2 bit4 masks switch drop over-voltage
// - mask2 bit3 masks input insertion, both edges
// - mask2 bit2 masks battery insertion, both edges
// - mask2 bit1 masks die thermal shutdown
// - mask2 bit0 masks input over-current event
// - masks zero on reset, pin fall, command, watchdog
// - flags set by event, cleared on read
`ifndef CHARGER_REGS_PARAMS_SVH
`define CHARGER_REGS_PARAMS_SVH

`define OFS_ID 8'h00
`define OFS_MASK1 8'h01
`define OFS_MASK2 8'h02
`define OFS_FLAG1 8'h03
`define OFS_FLAG2 8'h04

`define MASK_RESET 8'h00
`define FLAG_RESET 8'h00
`define READ_ZERO 8'h00
`define MASK2_USED 8'h7F
`define FLAG2_USED 8'h7F
`define ID_UNUSED 2'h0

// arbitrary values, not those of any real part
`define REV_DEFAULT 3'h5
`define PART_DEFAULT 3'h3
`define DEV_ADDR_DEFAULT 7'h2A

`define BIT_HI 7
`define BIT_6 6
`define BIT_5 5
`define BIT_4 4
`define BIT_3 3
`define BIT_2 2
`define BIT_1 1
`define BIT_0 0

`define BITS_PER_BYTE 4'h8
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define PTR_STEP 8'h01
`define EVENT_COUNT 15
`define SYNC_STAGES 2

`endif

//--- verilog/charger_regs_pkg.sv
// types shared by the charger mask/id register block.
// assumes charger_regs_params.svh is on the include path.
`default_nettype none
`include "charger_regs_params.svh"

package charger_regs_pkg;

    typedef struct packed {
        logic input_overvoltage_mask;
        logic input_current_reg_mask;
        logic battery_voltage_reg_mask;
        logic battery_current_reg_mask;
        logic output_voltage_reg_mask;
        logic input_thermistor_hot_mask;
        logic battery_thermistor_hot_mask;
        logic reverse_current_mask;
    } mask_one_t;

    typedef struct packed {
        logic unused_top;
        logic conversion_complete_mask;
        logic drop_alarm_mask;
        logic drop_overvoltage_mask;
        logic input_insertion_mask;
        logic battery_insertion_mask;
        logic thermal_shutdown_mask;
        logic input_overcurrent_mask;
    } mask_two_t;

    typedef struct packed {
        logic [1:0] unused_top;
        logic [2:0] silicon_revision;
        logic [2:0] part_code_field;
    } chip_id_t;

    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_REG,
        BUS_REG_ACK,
        BUS_WDATA,
        BUS_WDATA_ACK,
        BUS_RDATA,
        BUS_RDATA_ACK
    } bus_state_t;

endpackage : charger_regs_pkg

`default_nettype wire

//--- verilog/level_sync.sv
// two-flop synchroniser for a vector of independent asynchronous levels.
// assumes each bit is a slow level; multi-bit words are not kept coherent.
`default_nettype none
`include "charger_regs_params.svh"

module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // the first stage feeds only the second stage
    always_comb begin
        s_d = s_q;
        s_d.first = async_i;
        s_d.second = s_q.first;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q <= {INIT, INIT};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.second;
endmodule // level_sync

`default_nettype wire

//--- verilog/event_flag_bank.sv
// sticky event flags, read-clear, with mask gating onto one interrupt pin.
// assumes events are already synchronised to clock_i.
`default_nettype none
`include "charger_regs_params.svh"

module event_flag_bank #(
    parameter int EVENTS = `EVENT_COUNT
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clear_all_i,
    input wire logic [EVENTS-1:0] event_i,
    input wire logic [EVENTS-1:0] mask_i,
    input wire logic clear_low_i,
    input wire logic clear_high_i,
    output logic [EVENTS-1:0] flags_o,
    output logic int_n_o
);
    typedef struct packed {
        logic [EVENTS-1:0] flags;
        logic int_n;
    } flag_state_t;

    flag_state_t s_q;
    flag_state_t s_d;
    logic [EVENTS-1:0] next_flags;

    // low byte is group one, upper bits group two
    genvar g;
    generate
        for (g = 0; g < EVENTS; g++) begin : gen_flag
            logic clr;
            assign clr = (g < `BITS_PER_BYTE) ? clear_low_i : clear_high_i;
            // an event in the clearing cycle survives the clear
            assign next_flags[g] = event_i[g] | (s_q.flags[g] & ~clr);
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.flags = next_flags;
        // masked flags still latch, they just stay off the pin
        s_d.int_n = ~|(next_flags & ~mask_i);
        if (clear_all_i) begin
            s_d.flags = '0;
            s_d.int_n = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q <= '{flags: '0, int_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign flags_o = s_q.flags;
    assign int_n_o = s_q.int_n;
endmodule // event_flag_bank

`default_nettype wire

//--- verilog/charger_irq_mask_id_regs.sv
// two-wire serial slave holding the chip id, two event mask registers
// and the two read-clear event flag registers that the masks gate.
// assumes scl/sda are open-drain pins resolved outside, and that the
// register-reset command bit and watchdog expiry arrive as clock_i pulses.
`default_nettype none
`include "charger_regs_params.svh"

module charger_irq_mask_id_regs
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
    parameter logic [2:0] REVISION = `REV_DEFAULT,
    parameter logic [2:0] PART_CODE = `PART_DEFAULT
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic reset_n_pin_i,
    input wire logic reg_reset_cmd_i,
    input wire logic watchdog_expired_i,
    input wire logic [`EVENT_COUNT-1:0] event_i,
    output logic int_n_o
);

    typedef struct packed {
        bus_state_t st;
        logic scl_prev;
        logic sda_prev;
        logic rstn_prev;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] obyte;
        logic [7:0] ptr;
        logic rw;
        logic acked;
        logic sda_oe;
        logic clr_low;
        logic clr_high;
        mask_one_t mask1;
        mask_two_t mask2;
    } regs_state_t;

    regs_state_t s_q;
    regs_state_t s_d;

    localparam int SYNC_W = 3 + `EVENT_COUNT;
    localparam logic [SYNC_W-1:0] SYNC_INIT = {3'b111, {`EVENT_COUNT{1'b0}}};

    logic [SYNC_W-1:0] sync_out;
    logic scl_s;
    logic sda_s;
    logic rstn_s;
    logic [`EVENT_COUNT-1:0] event_s;
    logic [`EVENT_COUNT-1:0] flags;
    logic [`EVENT_COUNT-1:0] mask_vec;
    logic pin_fall;
    logic mask_clear;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    chip_id_t chip_id;
    logic [7:0] rd_data;
    logic byte_done;
    logic addr_match;
    logic flag1_sel;
    logic flag2_sel;
    logic rd_msb;
    logic [2:0] bit_sel;
    logic [7:0] next_ptr;
    logic [7:0] id_byte;
    logic [7:0] mask2_byte;
    logic [7:0] flag1_byte;
    logic [7:0] flag2_byte;

    // scl, sda, the reset pin and the events cross through two flops; the command and watchdog inputs are used unsynchronised
    level_sync #(
        .WIDTH(SYNC_W),
        .INIT(SYNC_INIT)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({scl_i, sda_i, reset_n_pin_i, event_i}),
        .sync_o(sync_out)
    );

    assign scl_s = sync_out[SYNC_W-1];
    assign sda_s = sync_out[SYNC_W-2];
    assign rstn_s = sync_out[SYNC_W-3];
    assign event_s = sync_out[`EVENT_COUNT-1:0];

    // a falling reset pin, the reset command or watchdog expiry all clear
    assign pin_fall = s_q.rstn_prev & ~rstn_s;
    assign mask_clear = pin_fall | reg_reset_cmd_i | watchdog_expired_i;

    assign start_seen = s_q.scl_prev & scl_s & s_q.sda_prev & ~sda_s;
    assign stop_seen = s_q.scl_prev & scl_s & ~s_q.sda_prev & sda_s;
    assign scl_rise = ~s_q.scl_prev & scl_s;
    assign scl_fall = s_q.scl_prev & ~scl_s;

    // shared decodes keep every byte-end test and pointer step identical
    assign byte_done = (s_q.cnt == `BITS_PER_BYTE);
    assign addr_match = (s_q.shift[7:1] == DEV_ADDR);
    assign next_ptr = s_q.ptr + `PTR_STEP;
    assign flag1_sel = (s_q.ptr == `OFS_FLAG1);
    assign flag2_sel = (s_q.ptr == `OFS_FLAG2);
    assign rd_msb = rd_data[`BIT_HI];
    // msb first: after n bits have gone out, bit 7-n is next
    assign bit_sel = 3'(`BIT_HI - s_q.cnt);

    // identification fields are constants, writes never reach them
    always_comb begin
        chip_id.unused_top = `ID_UNUSED;
        chip_id.silicon_revision = REVISION;
        chip_id.part_code_field = PART_CODE;
    end

    // reserved bits are forced where each byte is formed, so a read
    // can never expose whatever a stray write left in them
    assign id_byte = chip_id;
    assign mask2_byte = s_q.mask2 & `MASK2_USED;
    assign flag1_byte = flags[7:0];
    assign flag2_byte = {1'b0, flags[`EVENT_COUNT-1:8]};

    // read mux; unmapped offsets read zero
    always_comb begin
        unique case (s_q.ptr)
            `OFS_ID: rd_data = id_byte;
            `OFS_MASK1: rd_data = s_q.mask1;
            `OFS_MASK2: rd_data = mask2_byte;
            `OFS_FLAG1: rd_data = flag1_byte;
            `OFS_FLAG2: rd_data = flag2_byte;
            default: rd_data = `READ_ZERO;
        endcase
    end

    // group one fills bits 7:0, group two bits 14:8 of the event vector
    assign mask_vec = {s_q.mask2[6:0], s_q.mask1};

    event_flag_bank #(
        .EVENTS(`EVENT_COUNT)
    ) u_flags (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clear_all_i(mask_clear),
        .event_i(event_s),
        .mask_i(mask_vec),
        .clear_low_i(s_q.clr_low),
        .clear_high_i(s_q.clr_high),
        .flags_o(flags),
        .int_n_o(int_n_o)
    );

    always_comb begin
        s_d = s_q;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        s_d.rstn_prev = rstn_s;
        s_d.clr_low = 1'b0;
        s_d.clr_high = 1'b0;

        if (start_seen) begin
            s_d.st = BUS_ADDR;
            s_d.cnt = `CNT_ZERO;
            s_d.sda_oe = 1'b0;
        end else if (stop_seen) begin
            s_d.st = BUS_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (s_q.st)
                BUS_ADDR, BUS_REG, BUS_WDATA: begin
                    s_d.shift = {s_q.shift[6:0], sda_s};
                    s_d.cnt = s_q.cnt + `CNT_ONE;
                end
                BUS_RDATA: begin
                    s_d.cnt = s_q.cnt + `CNT_ONE;
                end
                BUS_RDATA_ACK: begin
                    s_d.acked = ~sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (s_q.st)
                BUS_IDLE: begin
                    // clocks with no start in front are other traffic
                end
                BUS_ADDR: begin
                    if (byte_done) begin
                        if (addr_match) begin
                            // ack by pulling low until the next scl fall
                            s_d.st = BUS_ADDR_ACK;
                            s_d.rw = s_q.shift[0];
                            s_d.sda_oe = 1'b1;
                        end else begin
                            // another device: stay off sda until a start
                            s_d.st = BUS_IDLE;
                        end
                    end
                end
                BUS_ADDR_ACK: begin
                    s_d.cnt = `CNT_ZERO;
                    if (s_q.rw) begin
                        s_d.st = BUS_RDATA;
                        s_d.obyte = rd_data;
                        s_d.sda_oe = ~rd_msb;
                        s_d.ptr = next_ptr;
                        // the loaded byte is the one reported, so clear now
                        s_d.clr_low = flag1_sel;
                        s_d.clr_high = flag2_sel;
                    end else begin
                        s_d.st = BUS_REG;
                        s_d.sda_oe = 1'b0;
                    end
                end
                BUS_REG: begin
                    if (byte_done) begin
                        // the offset byte sets the pointer, data steps it
                        s_d.ptr = s_q.shift;
                        s_d.st = BUS_REG_ACK;
                        s_d.sda_oe = 1'b1;
                    end
                end
                BUS_REG_ACK: begin
                    s_d.st = BUS_WDATA;
                    s_d.cnt = `CNT_ZERO;
                    s_d.sda_oe = 1'b0;
                end
                BUS_WDATA: begin
                    if (byte_done) begin
                        s_d.st = BUS_WDATA_ACK;
                        s_d.sda_oe = 1'b1;
                        s_d.ptr = next_ptr;
                        if (s_q.ptr == `OFS_MASK1) begin
                            s_d.mask1.input_overvoltage_mask =
                                s_q.shift[`BIT_HI];
                            s_d.mask1.input_current_reg_mask =
                                s_q.shift[`BIT_6];
                            s_d.mask1.battery_voltage_reg_mask =
                                s_q.shift[`BIT_5];
                            s_d.mask1.battery_current_reg_mask =
                                s_q.shift[`BIT_4];
                            s_d.mask1.output_voltage_reg_mask =
                                s_q.shift[`BIT_3];
                            s_d.mask1.input_thermistor_hot_mask =
                                s_q.shift[`BIT_2];
                            s_d.mask1.battery_thermistor_hot_mask =
                                s_q.shift[`BIT_1];
                            s_d.mask1.reverse_current_mask =
                                s_q.shift[`BIT_0];
                        end
                        if (s_q.ptr == `OFS_MASK2) begin
                            s_d.mask2.unused_top = 1'b0;
                            s_d.mask2.conversion_complete_mask =
                                s_q.shift[`BIT_6];
                            s_d.mask2.drop_alarm_mask =
                                s_q.shift[`BIT_5];
                            s_d.mask2.drop_overvoltage_mask =
                                s_q.shift[`BIT_4];
                            s_d.mask2.input_insertion_mask =
                                s_q.shift[`BIT_3];
                            s_d.mask2.battery_insertion_mask =
                                s_q.shift[`BIT_2];
                            s_d.mask2.thermal_shutdown_mask =
                                s_q.shift[`BIT_1];
                            s_d.mask2.input_overcurrent_mask =
                                s_q.shift[`BIT_0];
                        end
                    end
                end
                BUS_WDATA_ACK: begin
                    s_d.st = BUS_WDATA;
                    s_d.cnt = `CNT_ZERO;
                    s_d.sda_oe = 1'b0;
                end
                BUS_RDATA: begin
                    if (byte_done) begin
                        s_d.st = BUS_RDATA_ACK;
                        s_d.sda_oe = 1'b0;
                    end else begin
                        // msb first; drive low only, a one is released
                        s_d.sda_oe = ~s_q.obyte[bit_sel];
                    end
                end
                BUS_RDATA_ACK: begin
                    if (s_q.acked) begin
                        s_d.st = BUS_RDATA;
                        s_d.cnt = `CNT_ZERO;
                        s_d.obyte = rd_data;
                        s_d.sda_oe = ~rd_msb;
                        s_d.ptr = next_ptr;
                        s_d.clr_low = flag1_sel;
                        s_d.clr_high = flag2_sel;
                    end else begin
                        // master nack ends the read; wait for the stop
                        s_d.st = BUS_IDLE;
                    end
                end
            endcase
        end

        // clearing wins over a write in the same cycle, the reset is the
        // stronger request and writes are rare next to it
        if (mask_clear) begin
            s_d.mask1 = `MASK_RESET;
            s_d.mask2 = `MASK_RESET;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q <= '{
                st: BUS_IDLE,
                scl_prev: 1'b1,
                sda_prev: 1'b1,
                rstn_prev: 1'b1,
                cnt: `CNT_ZERO,
                shift: `READ_ZERO,
                obyte: `READ_ZERO,
                ptr: `READ_ZERO,
                rw: 1'b0,
                acked: 1'b0,
                sda_oe: 1'b0,
                clr_low: 1'b0,
                clr_high: 1'b0,
                mask1: `MASK_RESET,
                mask2: `MASK_RESET
            };
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: the pin is only ever pulled low
    assign sda_o = 1'b0;
    assign sda_oe_o = s_q.sda_oe;
endmodule // charger_irq_mask_id_regs

`default_nettype wire

//--- verif/charger_irq_mask_id_regs_properties.sv
// checker for the charger mask/id block, watching top-level ports only.
// assumes one clock domain with a synchronous active-high reset.
`default_nettype none
`include "charger_regs_params.svh"
module charger_irq_mask_id_regs_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic reset_n_pin_i,
    input wire logic reg_reset_cmd_i,
    input wire logic watchdog_expired_i,
    input wire logic [`EVENT_COUNT-1:0] event_i,
    input wire logic int_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence cleared_s;
        (reg_reset_cmd_i || watchdog_expired_i) ##1 1'b1;
    endsequence
    sequence held_event_s;
        (event_i != '0 && reset_n_pin_i && !reg_reset_cmd_i
            && !watchdog_expired_i)[*5];
    endsequence
    sequence calm_s;
        (event_i == '0)[*3];
    endsequence
    a_reset_idle: assert property (disable iff (1'b0)
        $fell(rst_i) |-> int_n_o && !sda_oe_o)
        else $error("outputs not idle after reset");
    a_cmd_clears: assert property (reg_reset_cmd_i |=> int_n_o)
        else $error("command did not clear interrupt");
    a_wdog_clears: assert property (watchdog_expired_i |=> int_n_o)
        else $error("watchdog did not clear interrupt");
    a_event_raises_int: assert property (
        cleared_s ##0 held_event_s |-> !int_n_o)
        else $error("unmasked event gave no interrupt");
    a_no_event_quiet: assert property (
        $fell(rst_i) ##0 (event_i == '0)[*8] |-> int_n_o)
        else $error("interrupt without any event");
    a_pin_fall_clears: assert property (
        calm_s ##1 ($fell(reset_n_pin_i) && event_i == '0)
        ##1 (event_i == '0)[*5] |-> int_n_o)
        else $error("pin reset did not clear interrupt");
    a_open_drain: assert property (!sda_o)
        else $error("data line driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line changed while clock high");
    // flags stick until a read (scl low) or a clear source releases them
    a_flag_holds: assert property (
        $rose(int_n_o) |-> !$past(scl_i) || $past(reg_reset_cmd_i)
        || $past(watchdog_expired_i) || !$past(reset_n_pin_i, 3))
        else $error("interrupt released with no clear source");
endmodule // charger_irq_mask_id_regs_checker

bind charger_irq_mask_id_regs charger_irq_mask_id_regs_checker checker_inst (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .reset_n_pin_i(reset_n_pin_i),
    .reg_reset_cmd_i(reg_reset_cmd_i),
    .watchdog_expired_i(watchdog_expired_i),
    .event_i(event_i),
    .int_n_o(int_n_o)
);
`default_nettype wire

//--- verif/i2c_host_model.sv
// behavioural two-wire bus host reaching the register block.
// assumes a pull-up on sda; scl phases of 8 clocks leave room for sync lag.
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] DEV = 7'h00
) (
    input wire logic clock_i,
    input wire logic dev_oe_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pull_q;
    // pull-up: a released line reads high, never the last driven value
    assign sda_o = !(pull_q || dev_oe_i);
    initial begin
        pull_q = 1'b0;
        scl_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // sda only moves 4 clocks into scl low, so the sync never sees a start
    task automatic bit_x(input logic b, output logic r);
        tick(4);
        pull_q = !b;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        r = sda_o;
        scl_o = 1'b0;
    endtask
    task automatic start_c();
        tick(4);
        pull_q = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        pull_q = 1'b1;
        tick(8);
        scl_o = 1'b0;
    endtask
    task automatic stop_c();
        tick(4);
        pull_q = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        pull_q = 1'b0;
        tick(8);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_x(1'b1, r);
            d = {d[6:0], r};
        end
        bit_x(1'b1, r);
    endtask
    task automatic write_reg(input logic [7:0] o, input logic [7:0] d);
        logic a;
        start_c();
        put_byte({DEV, 1'b0}, a);
        put_byte(o, a);
        put_byte(d, a);
        stop_c();
    endtask
    task automatic read_reg(input logic [7:0] o, output logic [7:0] d);
        logic a;
        start_c();
        put_byte({DEV, 1'b0}, a);
        put_byte(o, a);
        start_c();
        put_byte({DEV, 1'b1}, a);
        get_byte(d);
        stop_c();
    endtask
endmodule // i2c_host_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the charger mask/id register block.
// assumes the host model as bus partner and the bound port checker.
`default_nettype none
`include "charger_regs_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i, rst_i, cmd, wdog, pin_n, int_n, scl, sda, sda_oe;
    logic [`EVENT_COUNT-1:0] ev;
    int miscompares = 0;
    int n_tests = 0;
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = !clock_i;
    end
    charger_irq_mask_id_regs charger_irq_mask_id_regs_inst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(),
        .sda_oe_o(sda_oe),
        .reset_n_pin_i(pin_n),
        .reg_reset_cmd_i(cmd),
        .watchdog_expired_i(wdog),
        .event_i(ev),
        .int_n_o(int_n)
    );
    i2c_host_model #(.DEV(`DEV_ADDR_DEFAULT)) i2c_host_model_inst (
        .clock_i(clock_i),
        .dev_oe_i(sda_oe),
        .scl_o(scl),
        .sda_o(sda)
    );
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        i2c_host_model_inst.tick(n);
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        i2c_host_model_inst.write_reg(o, d);
    endtask
    task automatic rd(input logic [7:0] o, output logic [7:0] d);
        i2c_host_model_inst.read_reg(o, d);
    endtask
    task automatic pulse(input logic wd);
        tick(1);
        if (wd) wdog = 1'b1;
        else cmd = 1'b1;
        tick(1);
        wdog = 1'b0;
        cmd = 1'b0;
    endtask
    task automatic t_reset_values();
        logic [7:0] v;
        logic [7:0] id;
        id = {`ID_UNUSED, `REV_DEFAULT, `PART_DEFAULT};
        rd(8'h00, v);
        chk8(v, id);
        rd(8'h01, v);
        chk8(v, 8'h00);
        rd(8'h02, v);
        chk8(v, 8'h00);
        wr(8'h00, 8'hFF);
        rd(8'h00, v);
        chk8(v, id);
    endtask
    task automatic t_mask_bits();
        logic [7:0] v, m, m2;
        for (int b = 0; b < 8; b++) begin
            m = 8'h01 << b;
            m2 = m & 8'h7F;
            wr(8'h01, m);
            rd(8'h01, v);
            chk8(v, m);
            wr(8'h02, m);
            rd(8'h02, v);
            chk8(v, m2);
        end
    endtask
    task automatic t_gating();
        logic [7:0] v, m, o;
        for (int k = 0; k < `EVENT_COUNT; k++) begin
            o = (k < 8) ? 8'h01 : 8'h02;
            m = 8'h01 << (k % 8);
            pulse(1'b0);
            wr(o, m);
            ev[k] = 1'b1;
            tick(6);
            chk1(int_n, 1'b1);
            ev[k] = 1'b0;
            tick(4);
            rd(o + 8'h02, v);
            chk8(v, m);
            rd(o + 8'h02, v);
            chk8(v, 8'h00);
            // watchdog must drop the mask, so the same event now interrupts
            pulse(1'b1);
            ev[k] = 1'b1;
            tick(5);
            chk1(int_n, 1'b0);
            ev[k] = 1'b0;
            tick(4);
        end
    endtask
    task automatic t_resets();
        logic [7:0] v;
        wr(8'h01, 8'hA5);
        pin_n = 1'b0;
        tick(10);
        pin_n = 1'b1;
        chk1(int_n, 1'b1);
        rd(8'h01, v);
        chk8(v, 8'h00);
        wr(8'h02, 8'hFF);
        rd(8'h02, v);
        chk8(v, 8'h7F);
        pulse(1'b0);
        rd(8'h02, v);
        chk8(v, 8'h00);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        rst_i = 1'b1;
        cmd = 1'b0;
        wdog = 1'b0;
        pin_n = 1'b1;
        ev = '0;
        tick(8);
        rst_i = 1'b0;
        tick(4);
        t_reset_values();
        t_mask_bits();
        t_gating();
        t_resets();
        stop_test();
    end
    // the run needs about 50k clocks; 80k means a hang
    initial begin
        #800_000;
        miscompares++;
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
